// >>> mbr_link_chk.sv
// mbr_link_chk: watches the byte link between the master and slave ends
// assumes: one clock domain; the slave's own address is handed in as OWN_ADDR
`default_nettype none
module mbr_link_chk #(
	parameter logic [7:0] OWN_ADDR = 8'h11 // slave address under test
) (
	input wire logic       CLK_SYS,
	input wire logic       RST_B,
	input wire logic       m2s_valid,
	input wire logic [7:0] m2s_data,
	input wire logic       m2s_end,
	input wire logic       s2m_valid,
	input wire logic [7:0] s2m_data,
	input wire logic       s2m_end
);
	timeunit 1ns;
	timeprecision 100ps;
	import mbr_pkg::*;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// ------------------------------------------------------------
	// frame trackers
	// ------------------------------------------------------------
	logic [7:0]  q_b [8]; // bytes of the last query
	logic [4:0]  q_cnt_q; // query bytes so far
	logic [4:0]  s_cnt_q; // answer bytes so far
	logic [15:0] mc_q;    // running crc of the query
	logic [15:0] sc_q;    // running crc of the answer
	logic        exc_q;   // answer carries an exception
	// crc step over one byte, low bit first
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		return r;
	endfunction : crc8
	// counters and crc restart at every frame end
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			q_cnt_q <= 5'h00;
			s_cnt_q <= 5'h00;
			mc_q    <= 16'hFFFF;
			sc_q    <= 16'hFFFF;
			exc_q   <= 1'b0;
		end else begin
			if (m2s_end) begin
				q_cnt_q <= 5'h00;
				mc_q    <= 16'hFFFF;
			end else if (m2s_valid) begin
				q_cnt_q <= q_cnt_q + 5'h01;
				mc_q    <= crc8(mc_q, m2s_data);
			end
			if (s2m_end) begin
				s_cnt_q <= 5'h00;
				sc_q    <= 16'hFFFF;
			end else if (s2m_valid) begin
				s_cnt_q <= s_cnt_q + 5'h01;
				sc_q    <= crc8(sc_q, s2m_data);
			end
			if (s2m_valid && s_cnt_q == 5'h01) exc_q <= s2m_data[7];
		end
	end
	// query bytes kept for judging the answer
	always_ff @(posedge CLK_SYS) begin
		if (m2s_valid && q_cnt_q < 5'h08) q_b[q_cnt_q[2:0]] <= m2s_data;
	end
	// ------------------------------------------------------------
	// link properties
	// ------------------------------------------------------------
	frame_end_a: assert property (m2s_end |-> $past(m2s_valid))
		else $error("query end not right after a byte");
	qry_crc_a: assert property (m2s_end |-> mc_q == 16'h0000)
		else $error("query crc residue wrong");
	rsp_crc_a: assert property (s2m_end |-> $past(s2m_valid) && sc_q == 16'h0000)
		else $error("answer crc residue wrong");
	rsp_start_a: assert property (m2s_end && q_cnt_q == 5'h08 && q_b[0] == OWN_ADDR
		|-> ##3 s2m_valid && s2m_data == OWN_ADDR) else $error("answer not started");
	no_reply_a: assert property (m2s_end && q_b[0] != OWN_ADDR |-> ##1 !s2m_valid [*8])
		else $error("answer to a foreign or broadcast query");
	fn_echo_a: assert property (s2m_valid && s_cnt_q == 5'h01
		|-> s2m_data == q_b[1] || s2m_data == (q_b[1] | 8'h80)) else $error("function byte wrong");
	size_byte_a: assert property (s2m_valid && s_cnt_q == 5'h02 && q_b[1] == FN_RD_REGS
		&& !exc_q |-> s2m_data == {q_b[5][6:0], 1'b0}) else $error("size byte wrong");
	echo_data_a: assert property (s2m_valid && s_cnt_q > 5'h01 && s_cnt_q < 5'h08
		&& q_b[1] != FN_RD_REGS && !exc_q |-> s2m_data == q_b[s_cnt_q[2:0]])
		else $error("write answer differs from query");
	rsp_len_a: assert property (s2m_end |-> s_cnt_q == (exc_q ? 5'h05 :
		(q_b[1] == FN_RD_REGS) ? 5'h05 + {q_b[5][3:0], 1'b0} : 5'h08))
		else $error("answer length wrong");
	// main scenarios reached
	c_read: cover property (s2m_end && q_b[1] == FN_RD_REGS && !exc_q);
	c_echo: cover property (s2m_end && q_b[1] == FN_WR_COIL && !exc_q);
	c_exc: cover property (s2m_end && exc_q);
	c_bcast: cover property (m2s_end && q_b[0] == ADDR_BCAST);
endmodule : mbr_link_chk
`default_nettype wire

// >>> mbr_link_if.sv
// mbr_link_if: byte link between bus master and slave
// assumes: both ends on CLK_SYS; end pulse stands for the silent interval
`default_nettype none
interface mbr_link_if;
	logic       m2s_valid; // master byte strobe
	logic [7:0] m2s_data;  // master byte
	logic       m2s_end;   // master frame end pulse
	logic       s2m_valid; // slave byte strobe
	logic [7:0] s2m_data;  // slave byte
	logic       s2m_end;   // slave frame end pulse

	modport dev (input m2s_valid, m2s_data, m2s_end,
		output s2m_valid, s2m_data, s2m_end);
	modport mst (output m2s_valid, m2s_data, m2s_end,
		input s2m_valid, s2m_data, s2m_end);
endinterface : mbr_link_if
`default_nettype wire

// >>> mbr_master.sv
// mbr_master: master end, sends one query and collects the answer
// assumes: user side holds command fields stable while CMD_VALID is high
`default_nettype none
module mbr_master #(
	parameter int TMO_CYC = mbr_pkg::RSP_TMO_CYC // answer wait, cycles
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	mbr_link_if.mst          LINK,
	input  wire logic        CMD_VALID,
	input  wire logic [7:0]  CMD_SLAVE,
	input  wire logic [7:0]  CMD_FUNC,
	input  wire logic [15:0] CMD_NUM,
	input  wire logic [15:0] CMD_DATA,
	output logic             CMD_READY,
	output logic             RSP_WORD_VALID,
	output logic [15:0]      RSP_WORD,
	output logic             RSP_DONE,
	output logic             RSP_OK,
	output logic             RSP_EXC,
	output logic [7:0]       RSP_EXC_CODE,
	output logic             RSP_TIMEOUT
);
	import mbr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {M_IDLE, M_SEND, M_END, M_WAIT} mbr_mst_t;

	mbr_mst_t    st_q,  st_d;   // sequencer state
	logic [7:0]  fr_q [0:5];    // query payload
	logic [7:0]  fr_d [0:5];
	logic [3:0]  ix_q,  ix_d;   // byte index
	logic [15:0] crc_q, crc_d;  // tx or rx crc
	logic [7:0]  bc_q,  bc_d;   // read size byte
	logic [7:0]  hi_q,  hi_d;   // held high byte
	logic [31:0] tmo_q, tmo_d;  // answer wait counter
	logic        tv_q,  tv_d;
	logic [7:0]  td_q,  td_d;
	logic        te_q,  te_d;
	logic        wv_q,  wv_d;
	logic [15:0] w_q,   w_d;
	logic        dn_q,  dn_d;
	logic        ok_q,  ok_d;
	logic        ex_q,  ex_d;
	logic [7:0]  ec_q,  ec_d;
	logic        to_q,  to_d;
	logic [15:0] link_addr;     // number turned into link address
	assign link_addr = CMD_NUM - ADDR_OFS;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// sends payload and crc, then, unless broadcast, gathers the answer or times out
	always_comb begin
		st_d = st_q;
		fr_d = fr_q;
		ix_d = ix_q;
		crc_d = crc_q;
		bc_d = bc_q;
		hi_d = hi_q;
		tmo_d = tmo_q;
		tv_d = 1'b0;
		td_d = td_q;
		te_d = 1'b0;
		wv_d = 1'b0;
		w_d = w_q;
		dn_d = 1'b0;
		ok_d = ok_q;
		ex_d = ex_q;
		ec_d = ec_q;
		to_d = to_q;
		case (st_q)
			M_IDLE: begin
				if (CMD_VALID && CMD_READY) begin
					// coil value and run source setup are the user's job
					fr_d[0] = CMD_SLAVE;
					fr_d[1] = CMD_FUNC;
					fr_d[2] = link_addr[15:8];
					fr_d[3] = link_addr[7:0];
					fr_d[4] = CMD_DATA[15:8];
					fr_d[5] = CMD_DATA[7:0];
					ix_d = 4'h0;
					crc_d = CRC_INIT;
					st_d = M_SEND;
				end
			end
			M_SEND: begin
				tv_d = 1'b1;
				if (ix_q < 4'h6) begin
					td_d = fr_q[ix_q[2:0]];
					crc_d = mbr_crc_step(crc_q, td_d);
				end else begin
					td_d = (ix_q == 4'h6) ? crc_q[7:0] : crc_q[15:8];
				end
				ix_d = ix_q + 4'h1;
				if (ix_q == QRY_LEN - 4'h1) begin
					st_d = M_END;
				end
			end
			M_END: begin
				te_d = 1'b1;
				ix_d = 4'h0;
				crc_d = CRC_INIT;
				tmo_d = 32'h0;
				ok_d = 1'b0;
				ex_d = 1'b0;
				if (fr_q[0] == ADDR_BCAST) begin
					dn_d = 1'b1;
					to_d = 1'b0;
					st_d = M_IDLE;
				end else begin
					st_d = M_WAIT;
				end
			end
			M_WAIT: begin
				tmo_d = tmo_q + 32'h1;
				if (LINK.s2m_valid) begin
					crc_d = mbr_crc_step(crc_q, LINK.s2m_data);
					if (ix_q != 4'hF) begin
						ix_d = ix_q + 4'h1;
					end
					if (ix_q == 4'h1) begin
						ex_d = LINK.s2m_data[7];
					end
					if (ix_q == 4'h2) begin
						bc_d = LINK.s2m_data;
						ec_d = LINK.s2m_data;
					end
					// read data pairs high then low
					if (fr_q[1] == FN_RD_REGS && !ex_q && ix_q >= 4'h3 &&
						{4'h0, ix_q} < bc_q + 8'h03) begin
						if (ix_q[0]) begin
							hi_d = LINK.s2m_data;
						end else begin
							wv_d = 1'b1;
							w_d = {hi_q, LINK.s2m_data};
						end
					end
				end
				if (LINK.s2m_end) begin
					dn_d = 1'b1;
					to_d = 1'b0;
					ok_d = (crc_q == CRC_RESIDUE) && (ix_q >= 4'h4);
					st_d = M_IDLE;
				end else if (tmo_q >= TMO_CYC - 1) begin
					dn_d = 1'b1;
					to_d = 1'b1;
					st_d = M_IDLE;
				end
			end
			default: st_d = M_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			st_q <= M_IDLE;
			for (int i = 0; i < 6; i++) begin
				fr_q[i] <= 8'h00;
			end
			ix_q <= 4'h0;
			crc_q <= CRC_INIT;
			bc_q <= 8'h00;
			hi_q <= 8'h00;
			tmo_q <= 32'h0;
			tv_q <= 1'b0;
			td_q <= 8'h00;
			te_q <= 1'b0;
			wv_q <= 1'b0;
			w_q <= 16'h0000;
			dn_q <= 1'b0;
			ok_q <= 1'b0;
			ex_q <= 1'b0;
			ec_q <= 8'h00;
			to_q <= 1'b0;
		end else begin
			st_q <= st_d;
			fr_q <= fr_d;
			ix_q <= ix_d;
			crc_q <= crc_d;
			bc_q <= bc_d;
			hi_q <= hi_d;
			tmo_q <= tmo_d;
			tv_q <= tv_d;
			td_q <= td_d;
			te_q <= te_d;
			wv_q <= wv_d;
			w_q <= w_d;
			dn_q <= dn_d;
			ok_q <= ok_d;
			ex_q <= ex_d;
			ec_q <= ec_d;
			to_q <= to_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic rdy_q; // idle flag, registered
	always_ff @(posedge CLK_SYS) begin
		rdy_q <= RST_B && (st_d == M_IDLE);
	end
	assign CMD_READY      = rdy_q;
	assign LINK.m2s_valid = tv_q;
	assign LINK.m2s_data  = td_q;
	assign LINK.m2s_end   = te_q;
	assign RSP_WORD_VALID = wv_q;
	assign RSP_WORD       = w_q;
	assign RSP_DONE       = dn_q;
	assign RSP_OK         = ok_q;
	assign RSP_EXC        = ex_q;
	assign RSP_EXC_CODE   = ec_q;
	assign RSP_TIMEOUT    = to_q;
endmodule : mbr_master
`default_nettype wire

// >>> mbr_pkg.sv
// mbr_pkg: shared constants and the crc step for both link ends
// assumes: one system clock; both ends on the same clock domain
`default_nettype none
package mbr_pkg;
	// ----------------------------------------------------------------
	// function and exception codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  FN_RD_REGS   = 8'h03; // read holding registers
	localparam logic [7:0]  FN_WR_COIL   = 8'h05; // write one coil
	localparam logic [7:0]  FN_WR_REG    = 8'h06; // write one holding register
	localparam logic [7:0]  FN_EXC_FLAG  = 8'h80; // added to a refused function
	localparam logic [7:0]  EXC_BAD_FN   = 8'h01; // function not supported
	localparam logic [7:0]  EXC_BAD_ADDR = 8'h02; // target not found
	localparam logic [7:0]  EXC_BAD_DATA = 8'h03; // data format refused
	localparam logic [7:0]  ADDR_BCAST   = 8'h00; // broadcast slave address
	// ----------------------------------------------------------------
	// field values and sizes
	// ----------------------------------------------------------------
	localparam logic [15:0] COIL_ON      = 16'hFF00; // change data for on
	localparam logic [15:0] COIL_OFF     = 16'h0000; // change data for off
	localparam logic [15:0] COIL_ADDR_MAX = 16'h001E; // coil 31 on the link
	localparam logic [15:0] RD_CNT_MAX   = 16'h0004; // registers per read
	localparam logic [15:0] ADDR_OFS     = 16'h0001; // number minus link address
	localparam logic [3:0]  QRY_LEN      = 4'h8;  // bytes in every query
	localparam logic [15:0] CRC_INIT     = 16'hFFFF; // crc start value
	localparam logic [15:0] CRC_POLY_REV = 16'hA001; // x16+x15+x2+1, reflected
	localparam logic [15:0] CRC_RESIDUE  = 16'h0000; // crc over frame and crc
	// ----------------------------------------------------------------
	// master answer timeout
	// ----------------------------------------------------------------
	localparam int          RSP_TMO_US   = 2000; // answer wait in us
	localparam int          CLK_MHZ      = 20;   // system clock rate
	localparam int          RSP_TMO_CYC  = RSP_TMO_US * CLK_MHZ;

	// one byte through the crc, low bit first
	function automatic logic [15:0] mbr_crc_step(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
		end
		return c;
	endfunction : mbr_crc_step
endpackage : mbr_pkg
`default_nettype wire

// >>> mbr_slave.sv
// mbr_slave: slave end, takes queries and builds answer frames
// assumes: user register file answers a read one cycle after the strobe
//
// Contract
// - read counted registers from start address
// - read answer: address, function, size, data, crc
// - size byte is twice register count
// - broadcast queries get no answer
// - register number is link address plus one
// - coil number is link address plus one
// - function 05h changes exactly one coil
// - FF00h sets coil, 0000h clears coil
// - master sets run source select to 03; mbr_master leaves this to the user
// - function 06h writes one holding register
// - failed read gets an exception answer
// - successful write answer echoes the query
// - exception: function plus 80h, code, nothing done
// - crc-16 ends frames; bad frames ignored
// - foreign slave address ignored silently
`default_nettype none
module mbr_slave (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	mbr_link_if.dev          LINK,
	input  wire logic [7:0]  MY_ADDR,
	output logic             REG_RD_EN,
	output logic [15:0]      REG_RD_NUM,
	input  wire logic [15:0] REG_RD_DATA,
	output logic             REG_WR_EN,
	output logic [15:0]      REG_WR_NUM,
	output logic [15:0]      REG_WR_DATA,
	output logic             COIL_WR_EN,
	output logic [15:0]      COIL_NUM,
	output logic             COIL_VAL
);
	import mbr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_RX, S_EVAL, S_HDR, S_RD_REQ, S_RD_WAIT, S_RD_HI, S_RD_LO, S_CRC, S_END
	} mbr_sst_t;
	typedef enum logic [1:0] {K_ECHO, K_READ, K_EXC} mbr_kind_t;

	mbr_sst_t    st_q,   st_d;     // sequencer state
	mbr_kind_t   kind_q, kind_d;   // answer kind
	logic [7:0]  rx_q [0:7];       // query bytes
	logic [7:0]  rx_d [0:7];
	logic [3:0]  rcnt_q, rcnt_d;   // bytes taken, saturates
	logic [15:0] crc_q,  crc_d;    // rx or tx crc
	logic [2:0]  tix_q,  tix_d;    // header byte index
	logic [15:0] left_q, left_d;   // registers still to send
	logic [7:0]  exc_q,  exc_d;    // exception code
	logic [7:0]  lo_q,   lo_d;     // low byte of a read word
	logic        crc_hi_q, crc_hi_d; // second crc byte next
	logic        tv_q, tv_d;       // tx strobe
	logic [7:0]  td_q, td_d;       // tx byte
	logic        te_q, te_d;       // tx end pulse
	logic        rde_q, rde_d;
	logic [15:0] rdn_q, rdn_d;
	logic        rwe_q, rwe_d;
	logic [15:0] rwn_q, rwn_d;
	logic [15:0] rwd_q, rwd_d;
	logic        cwe_q, cwe_d;
	logic [15:0] cn_q,  cn_d;
	logic        cv_q,  cv_d;

	logic [15:0] q_addr;           // query address field
	logic [15:0] q_data;           // query count or change data
	assign q_addr = {rx_q[2], rx_q[3]};
	assign q_data = {rx_q[4], rx_q[5]};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// takes a query, checks it, executes, then streams the answer
	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		rx_d = rx_q;
		rcnt_d = rcnt_q;
		crc_d = crc_q;
		tix_d = tix_q;
		left_d = left_q;
		exc_d = exc_q;
		lo_d = lo_q;
		crc_hi_d = crc_hi_q;
		tv_d = 1'b0;
		td_d = td_q;
		te_d = 1'b0;
		rde_d = 1'b0;
		rdn_d = rdn_q;
		rwe_d = 1'b0;
		rwn_d = rwn_q;
		rwd_d = rwd_q;
		cwe_d = 1'b0;
		cn_d = cn_q;
		cv_d = cv_q;
		case (st_q)
			S_RX: begin
				// gather bytes and run the crc over all of them
				if (LINK.m2s_valid) begin
					if (rcnt_q < QRY_LEN) begin
						rx_d[rcnt_q[2:0]] = LINK.m2s_data;
					end
					if (rcnt_q <= QRY_LEN) begin
						rcnt_d = rcnt_q + 4'h1;
					end
					crc_d = mbr_crc_step(crc_q, LINK.m2s_data);
				end
				if (LINK.m2s_end) begin
					// wrong length, bad crc, foreign or broadcast: drop
					if (rcnt_q == QRY_LEN && crc_q == CRC_RESIDUE
						&& rx_q[0] == MY_ADDR && rx_q[0] != ADDR_BCAST) begin
						st_d = S_EVAL;
					end
					rcnt_d = 4'h0;
					crc_d = CRC_INIT;
				end
			end
			S_EVAL: begin
				// crc already passed, so actions happen only now
				kind_d = K_EXC;
				exc_d = EXC_BAD_FN;
				if (rx_q[1] == FN_RD_REGS) begin
					if (q_data == 16'h0000 || q_data > RD_CNT_MAX) begin
						exc_d = EXC_BAD_DATA;
					end else begin
						kind_d = K_READ;
						left_d = q_data;
						rdn_d = q_addr + ADDR_OFS;
					end
				end else if (rx_q[1] == FN_WR_COIL) begin
					if (q_addr > COIL_ADDR_MAX) begin
						exc_d = EXC_BAD_ADDR;
					end else if (q_data != COIL_ON && q_data != COIL_OFF) begin
						exc_d = EXC_BAD_DATA;
					end else begin
						kind_d = K_ECHO;
						cwe_d = 1'b1;
						cn_d = q_addr + ADDR_OFS;
						cv_d = (q_data == COIL_ON);
					end
				end else if (rx_q[1] == FN_WR_REG) begin
					kind_d = K_ECHO;
					rwe_d = 1'b1;
					rwn_d = q_addr + ADDR_OFS;
					rwd_d = q_data;
				end
				tix_d = 3'h0;
				crc_hi_d = 1'b0;
				st_d = S_HDR;
			end
			S_HDR: begin
				// header bytes, or the whole echo
				tv_d = 1'b1;
				case (kind_q)
					K_ECHO: td_d = rx_q[tix_q];
					K_READ: begin
						// address, function, size byte
						if (tix_q == 3'h2) begin
							td_d = {left_q[6:0], 1'b0};
						end else begin
							td_d = rx_q[tix_q];
						end
					end
					default: begin
						if (tix_q == 3'h1) begin
							td_d = rx_q[1] | FN_EXC_FLAG;
						end else if (tix_q == 3'h2) begin
							td_d = exc_q;
						end else begin
							td_d = rx_q[0];
						end
					end
				endcase
				crc_d = mbr_crc_step(crc_q, td_d);
				tix_d = tix_q + 3'h1;
				if ((kind_q == K_ECHO && tix_q == 3'h5) ||
					(kind_q != K_ECHO && tix_q == 3'h2)) begin
					st_d = (kind_q == K_READ) ? S_RD_REQ : S_CRC;
				end
			end
			S_RD_REQ: begin
				// ask the register file for the next word
				rde_d = 1'b1;
				st_d = S_RD_WAIT;
			end
			S_RD_WAIT: begin
				st_d = S_RD_HI;
			end
			S_RD_HI: begin
				// high byte goes first
				tv_d = 1'b1;
				td_d = REG_RD_DATA[15:8];
				lo_d = REG_RD_DATA[7:0];
				crc_d = mbr_crc_step(crc_q, td_d);
				rdn_d = rdn_q + 16'h0001;
				left_d = left_q - 16'h0001;
				st_d = S_RD_LO;
			end
			S_RD_LO: begin
				tv_d = 1'b1;
				td_d = lo_q;
				crc_d = mbr_crc_step(crc_q, td_d);
				st_d = (left_q == 16'h0000) ? S_CRC : S_RD_REQ;
			end
			S_CRC: begin
				// low crc byte, high crc byte, then the end pulse
				tv_d = 1'b1;
				td_d = crc_hi_q ? crc_q[15:8] : crc_q[7:0];
				crc_hi_d = 1'b1;
				if (crc_hi_q) begin
					st_d = S_END;
				end
			end
			S_END: begin
				// end pulse after the last crc byte
				te_d = 1'b1;
				crc_d = CRC_INIT;
				st_d = S_RX;
			end
			default: st_d = S_RX;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			st_q <= S_RX;
			kind_q <= K_ECHO;
			for (int i = 0; i < 8; i++) begin
				rx_q[i] <= 8'h00;
			end
			rcnt_q <= 4'h0;
			crc_q <= CRC_INIT;
			tix_q <= 3'h0;
			left_q <= 16'h0000;
			exc_q <= 8'h00;
			lo_q <= 8'h00;
			crc_hi_q <= 1'b0;
			tv_q <= 1'b0;
			td_q <= 8'h00;
			te_q <= 1'b0;
			rde_q <= 1'b0;
			rdn_q <= 16'h0000;
			rwe_q <= 1'b0;
			rwn_q <= 16'h0000;
			rwd_q <= 16'h0000;
			cwe_q <= 1'b0;
			cn_q <= 16'h0000;
			cv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			rx_q <= rx_d;
			rcnt_q <= rcnt_d;
			crc_q <= crc_d;
			tix_q <= tix_d;
			left_q <= left_d;
			exc_q <= exc_d;
			lo_q <= lo_d;
			crc_hi_q <= crc_hi_d;
			tv_q <= tv_d;
			td_q <= td_d;
			te_q <= te_d;
			rde_q <= rde_d;
			rdn_q <= rdn_d;
			rwe_q <= rwe_d;
			rwn_q <= rwn_d;
			rwd_q <= rwd_d;
			cwe_q <= cwe_d;
			cn_q <= cn_d;
			cv_q <= cv_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.s2m_valid = tv_q;
	assign LINK.s2m_data  = td_q;
	assign LINK.s2m_end   = te_q;
	assign REG_RD_EN   = rde_q;
	assign REG_RD_NUM  = rdn_q;
	assign REG_WR_EN   = rwe_q;
	assign REG_WR_NUM  = rwn_q;
	assign REG_WR_DATA = rwd_q;
	assign COIL_WR_EN  = cwe_q;
	assign COIL_NUM    = cn_q;
	assign COIL_VAL    = cv_q;
endmodule : mbr_slave
`default_nettype wire

// >>> testbench.sv
// testbench: master and slave joined by one link, and a slave fed by hand
// assumes: 20 MHz clock; the register file answers one cycle after a read strobe
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import mbr_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        CLK_SYS = 1'b0; // system clock
	logic        RST_B   = 1'b0; // sync reset, low active
	logic        rd_en, wr_en, coil_en, coil_val, wr_en_b; // slave strobes
	logic [15:0] rd_num, wr_num, wr_data, coil_num, wr_num_b, wr_data_b;
	logic [15:0] rd_data = 16'h0000; // register file answer
	logic        cmd_valid = 1'b0; // command request
	logic [7:0]  cmd_slave = 8'h00, cmd_func = 8'h00;
	logic [15:0] cmd_num = 16'h0000, cmd_data = 16'h0000;
	logic        cmd_ready, w_valid, done, ok, exc, tmo; // master answer side
	logic [15:0] w_word;
	logic [7:0]  exc_code, rsp_code;
	logic [2:0]  rsp;                 // ok, exception, timeout at answer end
	logic [31:0] wr_last, wr_last_b;  // last register write seen
	logic [16:0] coil_last;           // last coil write seen
	logic [15:0] words[$], rd_nums[$]; // read words and read numbers
	logic [7:0]  b_bytes[$];          // answer bytes on the hand-fed link
	logic [47:0] exc_tab [5] = '{48'h03_0012_0000_03, 48'h03_0012_0005_03,
		48'h05_0020_FF00_02, 48'h05_0001_1234_03, 48'h2B_0001_0000_01};
	int          wr_n = 0, wr_n_b = 0, coil_n = 0, errors = 0, n_tests = 0;
	// ------------------------------------------------------------
	// design ends, link and checker
	// ------------------------------------------------------------
	mbr_link_if u_link ();
	mbr_link_if u_bad ();
	mbr_slave u_mbr_slave (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .LINK(u_link), .MY_ADDR(8'h11),
		.REG_RD_EN(rd_en), .REG_RD_NUM(rd_num), .REG_RD_DATA(rd_data), .REG_WR_EN(wr_en),
		.REG_WR_NUM(wr_num), .REG_WR_DATA(wr_data), .COIL_WR_EN(coil_en),
		.COIL_NUM(coil_num), .COIL_VAL(coil_val));
	mbr_slave u_mbr_slave_b (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .LINK(u_bad), .MY_ADDR(8'h08),
		.REG_RD_EN(), .REG_RD_NUM(), .REG_RD_DATA(16'h0000), .REG_WR_EN(wr_en_b),
		.REG_WR_NUM(wr_num_b), .REG_WR_DATA(wr_data_b), .COIL_WR_EN(), .COIL_NUM(),
		.COIL_VAL());
	mbr_master #(.TMO_CYC(200)) u_mbr_master (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
		.LINK(u_link), .CMD_VALID(cmd_valid), .CMD_SLAVE(cmd_slave), .CMD_FUNC(cmd_func),
		.CMD_NUM(cmd_num), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
		.RSP_WORD_VALID(w_valid), .RSP_WORD(w_word), .RSP_DONE(done), .RSP_OK(ok),
		.RSP_EXC(exc), .RSP_EXC_CODE(exc_code), .RSP_TIMEOUT(tmo));
	mbr_link_chk #(.OWN_ADDR(8'h11)) u_mbr_link_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
		.m2s_valid(u_link.m2s_valid), .m2s_data(u_link.m2s_data), .m2s_end(u_link.m2s_end),
		.s2m_valid(u_link.s2m_valid), .s2m_data(u_link.s2m_data), .s2m_end(u_link.s2m_end));
	// clock at 50 ns
	always #25 CLK_SYS = ~CLK_SYS;
	// user side: register file and logs of every strobe
	always @(posedge CLK_SYS) begin
		if (rd_en) begin
			rd_nums.push_back(rd_num);
			rd_data <= rd_num ^ 16'h5A5A;
		end
		if (w_valid) words.push_back(w_word);
		if (wr_en) begin
			wr_n++;
			wr_last = {wr_num, wr_data};
		end
		if (coil_en) begin
			coil_n++;
			coil_last = {coil_num, coil_val};
		end
		if (wr_en_b) begin
			wr_n_b++;
			wr_last_b = {wr_num_b, wr_data_b};
		end
		if (u_bad.s2m_valid) b_bytes.push_back(u_bad.s2m_data);
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one command through the master, answer fields kept in rsp
	task automatic xfer(input logic [7:0] sl, fn, input logic [15:0] num, dat);
		int t;
		words.delete();
		rd_nums.delete();
		{cmd_slave, cmd_func, cmd_num, cmd_data} = {sl, fn, num, dat};
		cmd_valid = 1'b1;
		t = 0;
		do begin @(posedge CLK_SYS); t++; end while (cmd_ready !== 1'b1 && t < 50);
		#2 cmd_valid = 1'b0;
		t = 0;
		do begin @(posedge CLK_SYS); t++; end while (done !== 1'b1 && t < 400);
		rsp = {ok, exc, tmo};
		rsp_code = exc_code;
		chk(done, 1'b1);
		#2;
	endtask : xfer
	function automatic logic [15:0] crc_of(input logic [47:0] p);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 5; i >= 0; i--) begin
			c = c ^ {8'h00, p[8 * i +: 8]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc_of
	// hand-made query: mode 0 good, 1 crc bytes swapped, 2 crc bit broken
	task automatic send_b(input logic [47:0] p, input int n, input int mode);
		logic [63:0] f;
		logic [15:0] c;
		c = crc_of(p);
		f = (mode == 1) ? {p, c} : {p, c[7:0], c[15:8]};
		f[0] = f[0] ^ (mode == 2);
		b_bytes.delete();
		for (int i = 0; i < n; i++) begin
			u_bad.m2s_valid = 1'b1;
			u_bad.m2s_data  = f[63 - 8 * i -: 8];
			@(posedge CLK_SYS) #2;
		end
		u_bad.m2s_valid = 1'b0;
		u_bad.m2s_data  = ~u_bad.m2s_data;
		u_bad.m2s_end   = 1'b1;
		@(posedge CLK_SYS) #2;
		u_bad.m2s_end = 1'b0;
		repeat (30) @(posedge CLK_SYS);
		#2;
	endtask : send_b
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{u_bad.m2s_valid, u_bad.m2s_data, u_bad.m2s_end} = 10'h000;
		repeat (6) @(posedge CLK_SYS);
		#2 RST_B = 1'b1;
		foreach (exc_tab[i]) begin
			xfer(8'h11, exc_tab[i][47:40], exc_tab[i][39:24], exc_tab[i][23:8]);
			chk({rsp, rsp_code}, {3'b110, exc_tab[i][7:0]});
			chk(wr_n + coil_n + rd_nums.size(), 0);
		end
		$display("exception answers done");
		for (int c = 1; c <= 4; c += 3) begin
			xfer(8'h11, FN_RD_REGS, 16'h0012, 16'(c));
			chk({rsp, words.size()}, {3'b100, 32'(c)});
			for (int i = 0; i < c; i++)
				chk({words[i], rd_nums[i]}, {(16'h0012 + 16'(i)) ^ 16'h5A5A, 16'h0012 + 16'(i)});
		end
		$display("register reads done");
		xfer(8'h11, FN_WR_COIL, 16'h0001, COIL_ON);
		chk({rsp, coil_last, coil_n}, {3'b100, 16'h0001, 1'b1, 32'h1});
		xfer(8'h11, FN_WR_COIL, 16'h001F, COIL_OFF);
		chk({rsp, coil_last, coil_n}, {3'b100, 16'h001F, 1'b0, 32'h2});
		xfer(8'h11, FN_WR_REG, 16'h1029, 16'h01F4);
		chk({rsp, wr_last, wr_n}, {3'b100, 32'h1029_01F4, 32'h1});
		$display("writes done");
		xfer(ADDR_BCAST, FN_WR_REG, 16'h1029, 16'h0BAD);
		repeat (20) @(posedge CLK_SYS);
		chk({rsp[2], wr_n}, {1'b0, 32'h1});
		xfer(8'h22, FN_WR_REG, 16'h1029, 16'h0BAD);
		chk({rsp[2], rsp[0], wr_n}, {2'b01, 32'h1});
		$display("silent queries done");
		for (int m = 0; m < 3; m++) begin
			send_b(48'h0806_1028_01F4, (m == 0) ? 7 : 8, m);
			chk({b_bytes.size(), wr_n_b}, 64'h0);
		end
		send_b(48'h0806_1028_01F4, 8, 0);
		chk({16'(b_bytes.size()), b_bytes[0], b_bytes[2], wr_last_b}, {16'h8, 16'h0810, 32'h1029_01F4});
		$display("hand-fed link done");
		final_report();
	end
	// watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		errors++;
		final_report();
	end
endmodule : testbench
`default_nettype wire
